// ===== design/sim_consts.svh
// Constants for the SDRAM init and mode register block.
// Assumes a 100 MHz clock; times are converted to cycles here.
`ifndef SIM_CONSTS_SVH
`define SIM_CONSTS_SVH
// Clock period
`define SIM_CLK_PERIOD_NS 10
// Power-up settle time
`define SIM_POWER_UP_US 100
`define SIM_POWER_UP_CYC (`SIM_POWER_UP_US * 1000 / `SIM_CLK_PERIOD_NS)
// Internal all-bank precharge time, rounded up
`define SIM_PRECHARGE_NS 20
`define SIM_PRECHARGE_CYC ((`SIM_PRECHARGE_NS + `SIM_CLK_PERIOD_NS - 1) / `SIM_CLK_PERIOD_NS)
// Mode load settle time, rounded up
`define SIM_MODE_LOAD_NS 20
`define SIM_MODE_LOAD_CYC ((`SIM_MODE_LOAD_NS + `SIM_CLK_PERIOD_NS - 1) / `SIM_CLK_PERIOD_NS)
// Mode register field positions
`define SIM_BURST_LSB 0
`define SIM_ORDER_BIT 3
`define SIM_LAT_LSB 4
`define SIM_OPMODE_LSB 7
`define SIM_WBURST_BIT 9
// Settings held before any load
`define SIM_MODE_DEFAULT 12'h030
// Refresh count needed before operation
`define SIM_MIN_REFRESH 2
`endif

// ===== design/sim_pkg.sv
// Types shared by the SDRAM init and mode register block.
// Assumes the pin command code is {row strobe, col strobe, write enable}.
package sim_pkg;
  // Pin commands, chip selected and clock enable high
  typedef enum logic [2:0] {
    CMD_LOAD = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVE = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_TERMINATE = 3'h6,
    CMD_NOP = 3'h7
  } sim_cmd_type;
  // Initialisation progress, Gray coded along the path
  typedef enum logic [2:0] {
    ST_POWER = 3'h0,
    ST_WAIT_PRE = 3'h1,
    ST_PRECH = 3'h3,
    ST_IDLE = 3'h2,
    ST_READY = 3'h6
  } sim_state_type;
endpackage

// ===== design/sim_fifo.sv
// Word FIFO between the array read side and the data pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sim_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // Pointers
  logic [AW:0] cnt_r, cnt_nxt; // Fill level
  logic push, pop;

  assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and level update
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule

// ===== design/sim_core.sv
// SDRAM power-up tracking, mode register and burst sequencing.
// Assumes pins are synchronous to clock_in; an array serves column beats.
`timescale 1ns/10ps
`include "sim_consts.svh"
// Notes on behaviour
// R1: Controller waits 100 us, only NOP/inhibit
// R2: Clock enable low, raised inside wait
// R3: Precharge all, then idle after wait
// R4: Two refreshes, each followed by wait
// R5: More refresh loops are allowed
// R6: Refreshes may follow the mode load
// R7: Mode unknown at power-up; defaults apply
// R8: Load selects mode when banks zero
// R9: Data pins released on mode load
// R10: Only NOPs during mode load wait
// R11: Load mode only with banks idle
// R12: Mode fields decode burst, latency, modes
// R13: Upper mode bits and banks zero
// R14: Lengths 1/2/4/8 plus sequential full page
// R15: Burst stays in aligned column block
// R16: Sequential adds, interleaved XORs offset
// R17: Full page wraps at row end
// R18: Length one ignores burst order
// R19: Read drives at n+m-1, valid n+m
// R20: Operating mode zero only is normal
// R21: Write burst bit forces single writes
// R22: Never program reserved field codes
// R23: Times round up to whole clocks
// R24: Burst and latency code assignments
module sim_core #(
  parameter int DQ_W = 16,
  parameter int COL_W = 9,
  parameter int ADDR_W = 12,
  parameter int FIFO_DEPTH = 8,
  parameter int POWER_UP_CYCLES = `SIM_POWER_UP_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Command pins
  input wire logic clock_enable_in,
  input wire logic chip_select_n_in,
  input wire logic row_strobe_n_in,
  input wire logic col_strobe_n_in,
  input wire logic write_enable_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [1:0] bank_select_in,
  // Data pins
  input wire logic [DQ_W-1:0] data_pins_in,
  output logic [DQ_W-1:0] data_pins_out,
  output logic data_pins_oe_out,
  // Array side
  output logic [COL_W-1:0] col_addr_out,
  output logic array_rd_req_out,
  input wire logic array_rd_valid_in,
  output logic array_rd_ready_out,
  input wire logic [DQ_W-1:0] array_rd_data_in,
  output logic array_wr_valid_out,
  output logic [DQ_W-1:0] array_wr_data_out,
  // Status
  output logic init_done_out,
  output logic mode_loaded_out,
  output logic seq_error_out,
  output logic [ADDR_W-1:0] mode_value_out
);
  localparam logic [15:0] PRE_CYC = 16'(`SIM_PRECHARGE_CYC);
  localparam logic [15:0] MRD_CYC = 16'(`SIM_MODE_LOAD_CYC);

  // Burst length from field code; reserved codes act as length one
  function automatic logic [3:0] len_of(input logic [2:0] code);
    if (code == 3'h1) return 4'h2;
    if (code == 3'h2) return 4'h4;
    if (code == 3'h3) return 4'h8;
    return 4'h1;
  endfunction

  // Column of one beat inside its block or page
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start,
      input logic [COL_W-1:0] beat, input logic [3:0] len, input logic full,
      input logic ilv);
    logic [COL_W-1:0] mask;
    mask = full ? '1 : COL_W'(len - 4'h1);
    if (ilv && !full) begin
      return (start & ~mask) | ((start ^ beat) & mask); // R16
    end
    return (start & ~mask) | ((start + beat) & mask); // R15 R17
  endfunction

  sim_pkg::sim_cmd_type cmd; // Decoded command this edge
  sim_pkg::sim_state_type st_r, st_nxt; // Init progress
  logic [15:0] cnt_r, cnt_nxt; // Wait counter
  logic [1:0] ref_r, ref_nxt; // Refreshes seen, saturating
  logic [ADDR_W-1:0] mode_r, mode_nxt; // Mode register
  logic loaded_r, loaded_nxt; // Mode written since reset
  logic err_r, err_nxt; // Sequence violation seen
  logic [3:0] len_w; // Programmed burst length
  logic full_w, ilv_w, wsingle_w; // Decoded mode flags
  logic [1:0] lat_w; // Read latency in clocks
  logic can_load, rd_issue, wr_issue;
  logic act_r, act_nxt, wr_r, wr_nxt; // Burst running and its kind
  logic [COL_W-1:0] start_r, start_nxt, beat_r, beat_nxt, col_r, col_nxt;
  logic [3:0] blen_r, blen_nxt; // Length of the running burst
  logic rdreq_r, rdreq_nxt, wrv_r, wrv_nxt;
  logic [DQ_W-1:0] wrd_r, wrd_nxt, dq_r, dq_nxt;
  logic [2:0] pipe_r, pipe_nxt; // Read beats by age in clocks
  logic oe_r, oe_nxt, pop;
  logic fifo_valid;
  logic [DQ_W-1:0] fifo_data;

  // Command decode; clock enable low or deselect read as NOP
  always_comb begin
    cmd = sim_pkg::CMD_NOP;
    if (clock_enable_in && !chip_select_n_in) begin
      cmd = sim_pkg::sim_cmd_type'({row_strobe_n_in, col_strobe_n_in, write_enable_n_in});
    end
  end

  // Mode field decode
  always_comb begin
    len_w = len_of(mode_r[`SIM_BURST_LSB +: 3]); // R12 R24
    full_w = (mode_r[`SIM_BURST_LSB +: 3] == 3'h7); // R14 R24
    ilv_w = mode_r[`SIM_ORDER_BIT] && (len_w != 4'h1); // R18
    lat_w = (mode_r[`SIM_LAT_LSB +: 3] == 3'h2) ? 2'h2 : 2'h3; // R24
    wsingle_w = mode_r[`SIM_WBURST_BIT]; // R21
  end

  assign can_load = (st_r == sim_pkg::ST_IDLE || st_r == sim_pkg::ST_READY) && !act_r;
  assign rd_issue = (cmd == sim_pkg::CMD_READ) && (st_r == sim_pkg::ST_READY);
  assign wr_issue = (cmd == sim_pkg::CMD_WRITE) && (st_r == sim_pkg::ST_READY);

  // Init sequence and mode register next state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ref_nxt = ref_r;
    mode_nxt = mode_r;
    loaded_nxt = loaded_r;
    err_nxt = err_r;
    case (st_r)
      sim_pkg::ST_POWER: begin
        // Count out the power-up settle time
        cnt_nxt = cnt_r + 16'h1;
        if (cnt_r == 16'(POWER_UP_CYCLES - 1)) begin
          st_nxt = sim_pkg::ST_WAIT_PRE;
          cnt_nxt = '0;
        end
        if (cmd != sim_pkg::CMD_NOP) begin
          err_nxt = 1'b1;
        end
      end
      sim_pkg::ST_WAIT_PRE: begin
        // Wait for precharge of all banks
        if (cmd == sim_pkg::CMD_PRECHARGE && addr_in[10]) begin
          st_nxt = sim_pkg::ST_PRECH; // R3
          cnt_nxt = '0;
        end else if (cmd != sim_pkg::CMD_NOP) begin
          err_nxt = 1'b1;
        end
      end
      sim_pkg::ST_PRECH: begin
        // Banks finish precharging, then idle
        cnt_nxt = cnt_r + 16'h1;
        if (cnt_r == PRE_CYC - 16'h1) begin
          st_nxt = sim_pkg::ST_IDLE; // R3
          cnt_nxt = '0;
        end
        if (cmd != sim_pkg::CMD_NOP) begin
          err_nxt = 1'b1;
        end
      end
      default: begin
        // Idle or ready: refresh counting, mode loading
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 16'h1;
          if (cmd != sim_pkg::CMD_NOP) begin
            err_nxt = 1'b1;
          end
        end
        if (cmd == sim_pkg::CMD_REFRESH && ref_r != 2'h3) begin
          ref_nxt = ref_r + 2'h1; // R4 R5
        end
        if (cmd == sim_pkg::CMD_LOAD) begin
          if (!can_load) begin
            err_nxt = 1'b1;
          end else if (bank_select_in == 2'h0) begin
            mode_nxt = addr_in; // R8
            loaded_nxt = 1'b1;
            cnt_nxt = MRD_CYC;
            if (addr_in[`SIM_OPMODE_LSB +: 2] != 2'h0) begin
              err_nxt = 1'b1; // R20
            end
          end
        end
        if (st_r == sim_pkg::ST_IDLE && ref_r >= 2'(`SIM_MIN_REFRESH) && loaded_r) begin
          st_nxt = sim_pkg::ST_READY; // R4 R6
        end
      end
    endcase
  end

  // Init registers; mode starts at the unprogrammed defaults
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_r <= sim_pkg::ST_POWER;
      cnt_r <= '0;
      ref_r <= '0;
      mode_r <= ADDR_W'(`SIM_MODE_DEFAULT); // R7
      loaded_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ref_r <= ref_nxt;
      mode_r <= mode_nxt;
      loaded_r <= loaded_nxt;
      err_r <= err_nxt;
    end
  end

  // Burst sequencer: beat zero goes out with the command
  always_comb begin
    act_nxt = act_r;
    wr_nxt = wr_r;
    start_nxt = start_r;
    beat_nxt = beat_r;
    blen_nxt = blen_r;
    col_nxt = col_r;
    rdreq_nxt = 1'b0;
    wrv_nxt = 1'b0;
    wrd_nxt = wrd_r;
    if (rd_issue || wr_issue) begin
      // New command interrupts any running burst
      start_nxt = addr_in[COL_W-1:0];
      blen_nxt = (wr_issue && wsingle_w) ? 4'h1 : len_w; // R21
      act_nxt = ((wr_issue && wsingle_w) ? 1'b0 : full_w) || (blen_nxt != 4'h1); // R14
      wr_nxt = wr_issue;
      beat_nxt = COL_W'(1);
      col_nxt = addr_in[COL_W-1:0]; // R18
      rdreq_nxt = rd_issue;
      wrv_nxt = wr_issue;
      wrd_nxt = data_pins_in;
    end else if (cmd == sim_pkg::CMD_TERMINATE || cmd == sim_pkg::CMD_PRECHARGE ||
        cmd == sim_pkg::CMD_LOAD) begin
      act_nxt = 1'b0; // R14
    end else if (act_r) begin
      // Next beat of the running burst
      col_nxt = beat_col(start_r, beat_r, blen_r, full_w && blen_r == len_w, ilv_w);
      rdreq_nxt = !wr_r;
      wrv_nxt = wr_r;
      wrd_nxt = data_pins_in;
      beat_nxt = beat_r + COL_W'(1);
      if (!full_w && beat_r == COL_W'(blen_r - 4'h1)) begin
        act_nxt = 1'b0;
      end
    end
  end

  // Burst registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      act_r <= 1'b0;
      wr_r <= 1'b0;
      start_r <= '0;
      beat_r <= '0;
      blen_r <= 4'h1;
      col_r <= '0;
      rdreq_r <= 1'b0;
      wrv_r <= 1'b0;
      wrd_r <= '0;
    end else begin
      act_r <= act_nxt;
      wr_r <= wr_nxt;
      start_r <= start_nxt;
      beat_r <= beat_nxt;
      blen_r <= blen_nxt;
      col_r <= col_nxt;
      rdreq_r <= rdreq_nxt;
      wrv_r <= wrv_nxt;
      wrd_r <= wrd_nxt;
    end
  end

  // Read beats age in the pipe; pins driven from age m-1, data at age m
  assign pop = pipe_r[lat_w - 2'h1];
  always_comb begin
    pipe_nxt = {pipe_r[1:0], rdreq_nxt};
    oe_nxt = pipe_r[lat_w - 2'h2] || pipe_r[lat_w - 2'h1]; // R19
    dq_nxt = (pop && fifo_valid) ? fifo_data : dq_r;
    if (cmd == sim_pkg::CMD_LOAD) begin
      pipe_nxt = '0; // R9
      oe_nxt = 1'b0; // R9
    end
  end

  // Read output registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pipe_r <= '0;
      oe_r <= 1'b0;
      dq_r <= '0;
    end else begin
      pipe_r <= pipe_nxt;
      oe_r <= oe_nxt;
      dq_r <= dq_nxt;
    end
  end

  // Read data buffer, drained by due beats only
  sim_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(array_rd_valid_in),
    .in_ready_out(array_rd_ready_out),
    .in_data_in(array_rd_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_data)
  );

  assign data_pins_out = dq_r;
  assign data_pins_oe_out = oe_r;
  assign col_addr_out = col_r;
  assign array_rd_req_out = rdreq_r;
  assign array_wr_valid_out = wrv_r;
  assign array_wr_data_out = wrd_r;
  assign init_done_out = (st_r == sim_pkg::ST_READY);
  assign mode_loaded_out = loaded_r;
  assign seq_error_out = err_r;
  assign mode_value_out = mode_r;

  release_on_load_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R9
    cmd == sim_pkg::CMD_LOAD |=> !data_pins_oe_out ##1 !data_pins_oe_out)
    else $error("data pins driven after mode load");
  lat_two_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R19
    (rd_issue && lat_w == 2'h2) |=> ##1 data_pins_oe_out ##1 data_pins_oe_out)
    else $error("latency two drive window wrong");
  lat_three_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R19
    (rd_issue && lat_w == 2'h3 && pipe_r == '0) |=> !oe_r ##1 !oe_r ##1 oe_r)
    else $error("latency three drive start wrong");
  mode_load_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R8
    (cmd == sim_pkg::CMD_LOAD && can_load && bank_select_in == 2'h0) |=>
    mode_value_out == $past(addr_in) && mode_loaded_out)
    else $error("mode register not loaded");
  bank_guard_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R8
    (cmd == sim_pkg::CMD_LOAD && bank_select_in != 2'h0) |=> $stable(mode_value_out))
    else $error("mode changed with nonzero bank");
  prech_done_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R3
    $rose(st_r == sim_pkg::ST_PRECH) |-> ##(`SIM_PRECHARGE_CYC) st_r == sim_pkg::ST_IDLE)
    else $error("idle not reached after precharge");
  single_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R21
    (wr_issue && wsingle_w) |=> !act_r && array_wr_valid_out ##1 !array_wr_valid_out)
    else $error("write burst not single");
  len_one_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R18
    (rd_issue && len_w == 4'h1 && !full_w) |=> col_addr_out == $past(addr_in[COL_W-1:0]) && !act_r)
    else $error("length one burst wrong");
  pair_wrap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R15
    (rd_issue && len_w == 4'h2 && !full_w) |=> ##1 col_addr_out == ($past(col_addr_out) ^ COL_W'(1)))
    else $error("block of two order wrong");
  page_runs_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R14
    (act_r && full_w && blen_r == len_w && cmd == sim_pkg::CMD_NOP) |=> act_r)
    else $error("full page burst stopped");
endmodule

// ===== verif/sim_ctrl_model.sv
// Controller model: drives command, address, bank and write data pins.
// Assumes the bench calls its tasks; pins change on the falling edge.
`timescale 1ns/10ps
module sim_ctrl_model #(
  parameter int DQ_W = 16,
  parameter int ADDR_W = 12
) (
  // Clock
  input wire logic clock_in,
  // Command pins, cmd_out is {row, col, write} strobes
  output logic clock_enable_out,
  output logic chip_select_n_out,
  output logic [2:0] cmd_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [1:0] bank_select_out,
  output logic [DQ_W-1:0] data_out
);
  // Power-up pins: clock enable low, device deselected
  initial begin
    clock_enable_out = 1'b0;
    chip_select_n_out = 1'b1;
    cmd_out = 3'h7;
    addr_out = '0;
    bank_select_out = 2'h0;
    data_out = '0;
  end
  // Wait out the power-up time, raising clock enable midway
  task automatic power_up(input int n);
    repeat (n / 2) @(negedge clock_in);
    clock_enable_out = 1'b1;
    repeat (n - n / 2 + 2) @(negedge clock_in);
  endtask
  // One command for one edge, then NOP; returns just after that edge
  task automatic issue(input logic [2:0] cmd, input logic [ADDR_W-1:0] addr,
      input logic [1:0] bank, input logic [DQ_W-1:0] wdata);
    @(negedge clock_in);
    chip_select_n_out = 1'b0;
    cmd_out = cmd;
    addr_out = addr;
    bank_select_out = bank;
    data_out = wdata;
    @(negedge clock_in);
    // Only NOPs follow until the next call
    cmd_out = 3'h7;
    addr_out = ~addr;
    // Released data does not keep the last word
    data_out = ~wdata;
  endtask
  // Hold NOPs for n edges
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask
endmodule

// ===== verif/tb_top.sv
// Testbench: init sequence, mode loads, burst order, latency, FIFO.
// Assumes sim_core from design/ with its FIFO inside, controller model beside it.
`timescale 1ns/10ps
module tb_top;
  localparam int PU = 20;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cke, csn, oe, rd_req, rd_ready, wr_valid, i_done, m_done, s_err;
  logic [2:0] cmd;
  logic [11:0] addr, mode_val;
  logic [1:0] bank;
  logic [15:0] wdq, dq_out, wr_data;
  logic [8:0] col;
  logic rd_valid;
  logic [15:0] rd_data;
  logic pre_mode = 1'b0; // Array side offers preload words instead of beats
  logic pre_v = 1'b0; // Preload word offered
  logic [15:0] pre_d = '0; // Preload word
  int err_total = 0;
  int checks = 0;
  always #5 clock_in = ~clock_in;
  sim_ctrl_model u_ctrl (.clock_in(clock_in), .clock_enable_out(cke),
    .chip_select_n_out(csn), .cmd_out(cmd), .addr_out(addr),
    .bank_select_out(bank), .data_out(wdq));
  sim_core #(.POWER_UP_CYCLES(PU)) u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .clock_enable_in(cke), .chip_select_n_in(csn), .row_strobe_n_in(cmd[2]),
    .col_strobe_n_in(cmd[1]), .write_enable_n_in(cmd[0]), .addr_in(addr),
    .bank_select_in(bank), .data_pins_in(wdq), .data_pins_out(dq_out),
    .data_pins_oe_out(oe), .col_addr_out(col), .array_rd_req_out(rd_req),
    .array_rd_valid_in(rd_valid), .array_rd_ready_out(rd_ready),
    .array_rd_data_in(rd_data), .array_wr_valid_out(wr_valid),
    .array_wr_data_out(wr_data), .init_done_out(i_done), .mode_loaded_out(m_done),
    .seq_error_out(s_err), .mode_value_out(mode_val));
  // Stored word of a column
  function automatic logic [15:0] dat(input logic [8:0] c);
    return {7'h2d, c};
  endfunction
  // Column of beat k inside the aligned block of len columns
  function automatic logic [8:0] bcol(input logic [8:0] s, input int len, input logic ilv,
      input int k);
    logic [8:0] m;
    m = 9'(len - 1);
    if (ilv) begin
      return (s & ~m) | ((s ^ 9'(k)) & m);
    end
    return (s & ~m) | ((s + 9'(k)) & m);
  endfunction
  // Array answers each beat request at the falling edge of the same cycle; preload mode feeds words directly
  always @(negedge clock_in) begin
    rd_valid <= pre_mode ? pre_v : rd_req;
    rd_data <= pre_mode ? pre_d : (rd_req ? dat(col) : ~rd_data);
  end
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Mode load to bank 0, then the settle wait
  task automatic load(input logic [11:0] mode);
    u_ctrl.issue(3'h0, mode, 2'h0, '0);
    u_ctrl.idle(2);
    chk("mode", {4'h0, mode_val}, {4'h0, mode});
    chk("oe_load", {15'h0, oe}, 16'h0);
  endtask
  // Power-up, precharge all, then the mode load if load_first, then the refreshes
  task automatic init_seq(input bit load_first, input int nref);
    u_ctrl.power_up(PU);
    u_ctrl.issue(3'h2, 12'h400, 2'h0, '0);
    u_ctrl.idle(2);
    if (load_first) begin
      load(12'h022);
    end
    repeat (nref) begin
      u_ctrl.issue(3'h1, '0, 2'h0, '0);
      u_ctrl.idle(2);
    end
  endtask
  // Read burst: column order, drive start and data timing
  task automatic rd_test(input logic [11:0] mode, input logic [8:0] s, input int len,
      input int m);
    int nb;
    nb = (len > 8) ? 4 : len;
    load(mode);
    u_ctrl.issue(3'h5, {3'h0, s}, 2'h0, '0);
    for (int j = 0; j <= m + nb; j++) begin
      if (j < nb) begin
        chk("col", {7'h0, col}, {7'h0, bcol(s, len, mode[3], j)});
        chk("rd_req", {15'h0, rd_req}, 16'h1);
      end
      if (j >= m - 1 && j < m + nb) begin
        chk("oe", {15'h0, oe}, 16'h1);
      end
      if (j >= m && j < m + nb) begin
        chk("dq", dq_out, dat(bcol(s, len, mode[3], j - m)));
      end
      if (j == m + nb && len <= 8) begin
        chk("oe_end", {15'h0, oe}, 16'h0);
      end
      @(negedge clock_in);
    end
    if (len > 8) begin
      u_ctrl.issue(3'h6, '0, 2'h0, '0);
      u_ctrl.idle(8);
    end
    $display("read test mode %h done", mode);
  endtask
  // Write: data from the pins and count of beats
  task automatic wr_test(input logic [11:0] mode, input int n);
    int cnt;
    cnt = 0;
    load(mode);
    u_ctrl.issue(3'h4, 12'h010, 2'h0, 16'hc3a5);
    chk("wr_data", wr_data, 16'hc3a5);
    repeat (10) begin
      cnt += int'(wr_valid);
      @(negedge clock_in);
    end
    chk("wr_beats", 16'(cnt), 16'(n));
    $display("write test mode %h done", mode);
  endtask
  // Preload the read FIFO until refused, drain it by a burst, then read it empty
  task automatic fifo_test();
    load(12'h023);
    pre_mode <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      chk("fifo_ready", {15'h0, rd_ready}, {15'h0, i <= 8});
      pre_v <= (i < 9);
      pre_d <= 16'h0040 + 16'(i);
      @(negedge clock_in);
    end
    u_ctrl.issue(3'h5, 12'h000, 2'h0, '0);
    for (int j = 0; j < 12; j++) begin
      if (j >= 2 && j < 10) begin
        chk("fifo_data", dq_out, 16'h0040 + 16'(j - 2));
      end
      @(negedge clock_in);
    end
    chk("fifo_left", {15'h0, rd_ready}, 16'h1);
    u_ctrl.issue(3'h5, 12'h000, 2'h0, '0);
    u_ctrl.idle(3);
    chk("fifo_empty", dq_out, 16'h0047);
    pre_mode <= 1'b0;
    $display("fifo test done");
  endtask
  // Reset for 16 cycles, released on a falling edge
  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (16) @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk("rst_mode", {4'h0, mode_val}, 16'h0030);
    chk("rst_done", {15'h0, i_done}, 16'h0);
    chk("rst_err", {15'h0, s_err}, 16'h0);
  endtask
  // Watchdog
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    do_reset();
    init_seq(1'b0, 3);
    chk("done_early", {15'h0, i_done}, 16'h0);
    load(12'h022);
    chk("init_done", {15'h0, i_done}, 16'h1);
    chk("loaded", {15'h0, m_done}, 16'h1);
    $display("init test done");
    rd_test(12'h022, 9'h005, 4, 2);
    rd_test(12'h03b, 9'h00d, 8, 3);
    rd_test(12'h021, 9'h001, 2, 2);
    rd_test(12'h038, 9'h007, 1, 3);
    rd_test(12'h027, 9'h1fe, 512, 2);
    wr_test(12'h022, 4);
    wr_test(12'h222, 1);
    chk("no_err", {15'h0, s_err}, 16'h0);
    u_ctrl.issue(3'h0, 12'h021, 2'h1, '0);
    u_ctrl.idle(2);
    chk("bank_load", {4'h0, mode_val}, 16'h0222);
    u_ctrl.issue(3'h0, 12'h0a2, 2'h0, '0);
    u_ctrl.idle(2);
    chk("opmode_err", {15'h0, s_err}, 16'h1);
    fifo_test();
    do_reset();
    u_ctrl.issue(3'h1, '0, 2'h0, '0);
    u_ctrl.idle(1);
    chk("early_cmd", {15'h0, s_err}, 16'h1);
    $display("error test done");
    init_seq(1'b1, 2);
    chk("init_after", {15'h0, i_done}, 16'h1);
    $display("late refresh test done");
    test_done();
  end
endmodule
